// [src/kwm_pkg.sv]
// Package of register offsets, reset values and field positions for kwm.
package kwm_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets on the AXI4-Lite bus.
  // ---------------------------------------------------------------------
  localparam logic [7:0] KWM_OFF_KEY_MASK_HIGH  = 8'h00;
  localparam logic [7:0] KWM_OFF_KEY_MASK_LOW   = 8'h04;
  localparam logic [7:0] KWM_OFF_WAKE_MASK_HIGH = 8'h08;
  localparam logic [7:0] KWM_OFF_WAKE_MASK_LOW  = 8'h0C;
  localparam logic [7:0] KWM_OFF_SYS_CTRL_THREE = 8'h10;
  localparam logic [7:0] KWM_OFF_EVENT_STATUS   = 8'h14;
  localparam logic [7:0] KWM_OFF_EVENT_MASK     = 8'h18;

  // ---------------------------------------------------------------------
  // Values after reset.
  // ---------------------------------------------------------------------
  localparam logic [7:0] KWM_RST_KEY_MASK_HIGH  = 8'hFF;
  localparam logic [7:0] KWM_RST_KEY_MASK_LOW   = 8'hBF;
  localparam logic [7:0] KWM_RST_WAKE_MASK_HIGH = 8'hFF;
  localparam logic [7:0] KWM_RST_WAKE_MASK_LOW  = 8'hFF;
  localparam logic       KWM_RST_MODE           = 1'b0;
  localparam logic [3:0] KWM_RST_EVENT_STATUS   = 4'h0;
  localparam logic [3:0] KWM_RST_EVENT_MASK     = 4'h0;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int KWM_BIT_KEY_SIX   = 6;  // Key mask bit shared with pin six.
  localparam int KWM_BIT_MODE      = 0;  // Vector mode select in control.
  localparam int KWM_GRP_KEY_HIGH  = 0;  // Group event bit, key 15..8.
  localparam int KWM_GRP_KEY_LOW   = 1;  // Group event bit, key 7..0.
  localparam int KWM_GRP_WAKE_HIGH = 2;  // Group event bit, wake 15..8.
  localparam int KWM_GRP_WAKE_LOW  = 3;  // Group event bit, wake 7..0.

  // ---------------------------------------------------------------------
  // Bus answer codes.
  // ---------------------------------------------------------------------
  localparam logic [1:0] KWM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] KWM_RESP_SLVERR = 2'h2;

endpackage : kwm_pkg

// [src/kwm_top.sv]
// Key-sense and wake-up input masking with interrupt six/seven routing.
`timescale 1ns/10ps
module kwm_top
  import kwm_pkg::*;
#(
  parameter int ADDR_W = 8  // Width of the AXI4-Lite byte address.
) (
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Pins, all active low.
  input  wire logic [15:0]       key_sense_in,
  input  wire logic [15:0]       wakeup_in,
  input  wire logic              ext_int_six_pin_in,
  input  wire logic              ext_int_seven_pin_in,
  input  wire logic              alt_ext_int_six_pin_in,
  // Towards the interrupt controller.
  output logic                   ext_int_six_out,
  output logic                   ext_int_seven_out,
  output logic [3:0]             group_req_out,
  output logic                   irq_out
);

  // ---------------------------------------------------------------------
  // Functions.
  // ---------------------------------------------------------------------
  // Low while any input whose mask bit is zero is low.
  function automatic logic merge_low(input logic [7:0] pins,
                                     input logic [7:0] mask);
    merge_low = &(pins | mask);
  endfunction

  // High when a falling edge hits an unmasked input of a group.
  function automatic logic group_fall(input logic [7:0] prev,
                                      input logic [7:0] now,
                                      input logic [7:0] mask);
    group_fall = |(prev & ~now & ~mask);
  endfunction

  // ---------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------
  logic [7:0]        key_mask_high;   // Mask for key inputs 15..8.
  logic [7:0]        key_mask_low;    // Mask for key inputs 7..0.
  logic [7:0]        wake_mask_high;  // Mask for wake inputs 15..8.
  logic [7:0]        wake_mask_low;   // Mask for wake inputs 7..0.
  logic              vector_mode_select; // Zero compatible, one extended.
  logic [3:0]        event_status;    // Sticky group event flags.
  logic [3:0]        event_mask;      // One lets a flag reach irq_out.
  logic [33:0]       pin_meta;        // First synchroniser stage.
  logic [33:0]       pin_sync;        // Second synchroniser stage.
  logic [31:0]       pin_prev;        // Last key/wake level for edges.
  logic              aw_held;         // Write address captured.
  logic              w_held;          // Write data captured.
  logic [ADDR_W-1:0] aw_addr;         // Captured write address.
  logic [31:0]       w_data;          // Captured write data.
  logic [3:0]        w_strb;          // Captured write strobes.

  // Synchronised pin views.
  logic [15:0] key_s;
  logic [15:0] wake_s;
  logic        six_pin_s;
  logic        seven_pin_s;
  logic        alt_six_s;
  assign key_s       = pin_sync[15:0];
  assign wake_s      = pin_sync[31:16];
  assign six_pin_s   = pin_sync[32];
  assign seven_pin_s = pin_sync[33];
  logic alt_meta;  // Alternate pin first stage; second is alt_six_s.

  // Write happens when both halves are held and no answer is pending.
  logic       do_write;
  logic       wr_lane0;
  logic [3:0] group_evt;
  assign do_write = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_lane0 = do_write && w_strb[0];

  // ---------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------
  // Every pin is asynchronous, so two stages come before any logic. Idle
  // level of these active-low pins is high, which is the reset value.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pin_meta <= '1;
      pin_sync <= '1;
      alt_meta <= 1'b1;
      alt_six_s <= 1'b1;
      pin_prev <= '1;
    end else begin
      pin_meta <= {ext_int_seven_pin_in, ext_int_six_pin_in,
                   wakeup_in, key_sense_in};
      pin_sync <= pin_meta;
      alt_meta <= alt_ext_int_six_pin_in;
      alt_six_s <= alt_meta;
      pin_prev <= {wake_s, key_s};  // Edge history only.
    end
  end

  // ---------------------------------------------------------------------
  // Mask registers.
  // ---------------------------------------------------------------------
  // Only byte lane 0 carries the eight mask bits; other lanes are ignored.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      key_mask_high  <= KWM_RST_KEY_MASK_HIGH;
      key_mask_low   <= KWM_RST_KEY_MASK_LOW;
      wake_mask_high <= KWM_RST_WAKE_MASK_HIGH;
      wake_mask_low  <= KWM_RST_WAKE_MASK_LOW;
    end else begin
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_KEY_MASK_HIGH) begin
        key_mask_high <= w_data[7:0];
      end
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_WAKE_MASK_HIGH) begin
        wake_mask_high <= w_data[7:0];
      end
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_WAKE_MASK_LOW) begin
        wake_mask_low <= w_data[7:0];
      end
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_KEY_MASK_LOW) begin
        key_mask_low <= w_data[7:0];
      end else if (wr_lane0 && aw_addr[7:0] == KWM_OFF_SYS_CTRL_THREE &&
                   w_data[KWM_BIT_MODE] && !vector_mode_select) begin
        // Entering extended mode forces key bit six to its masked value,
        // since the pin six path it also guarded no longer exists.
        key_mask_low[KWM_BIT_KEY_SIX] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Mode select and interrupt registers.
  // ---------------------------------------------------------------------
  // Vector mode bit, and event mask (one lets a flag reach irq_out).
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      vector_mode_select <= KWM_RST_MODE;
      event_mask         <= KWM_RST_EVENT_MASK;
    end else begin
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_SYS_CTRL_THREE) begin
        vector_mode_select <= w_data[KWM_BIT_MODE];
      end
      if (wr_lane0 && aw_addr[7:0] == KWM_OFF_EVENT_MASK) begin
        event_mask <= w_data[3:0];
      end
    end
  end

  // Sticky flags; writing one clears, a new event in the same cycle wins.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      event_status <= KWM_RST_EVENT_STATUS;
    end else if (wr_lane0 && aw_addr[7:0] == KWM_OFF_EVENT_STATUS) begin
      event_status <= (event_status & ~w_data[3:0]) | group_evt;
    end else begin
      event_status <= event_status | group_evt;
    end
  end

  // Level interrupt, high while any enabled flag is set.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(event_status & event_mask);
    end
  end

  // ---------------------------------------------------------------------
  // Extended-mode group requests.
  // ---------------------------------------------------------------------
  // Each group raises one vector on any unmasked falling edge; which
  // input caused it is not recorded anywhere.
  always_comb begin
    group_evt = 4'h0;
    if (vector_mode_select) begin
      group_evt[KWM_GRP_KEY_HIGH]  =
        group_fall(pin_prev[15:8], key_s[15:8], key_mask_high);
      group_evt[KWM_GRP_KEY_LOW]   =
        group_fall(pin_prev[7:0], key_s[7:0], key_mask_low);
      group_evt[KWM_GRP_WAKE_HIGH] =
        group_fall(pin_prev[31:24], wake_s[15:8], wake_mask_high);
      group_evt[KWM_GRP_WAKE_LOW]  =
        group_fall(pin_prev[23:16], wake_s[7:0], wake_mask_low);
    end
  end

  // One-cycle group request pulses to the interrupt controller.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      group_req_out <= 4'h0;
    end else begin
      group_req_out <= group_evt;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt six and seven source levels.
  // ---------------------------------------------------------------------
  // Outputs are active-low levels; the sense logic downstream must use
  // low-level or falling-edge detection in compatible mode.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ext_int_six_out   <= 1'b1;
      ext_int_seven_out <= 1'b1;
    end else if (!vector_mode_select) begin
      // Pin six is passed only while key bit six is zero, and the
      // alternate pin is not looked at.
      ext_int_six_out <=
        merge_low(key_s[7:0], key_mask_low) &
        (six_pin_s | key_mask_low[KWM_BIT_KEY_SIX]);
      // Pin seven is ignored once any shared mask bit is zero.
      ext_int_seven_out <=
        merge_low(key_s[15:8], key_mask_high) &
        merge_low(wake_s[7:0], wake_mask_low) &
        (seven_pin_s |
         ~(&{key_mask_high, wake_mask_low}));
    end else begin
      // Key bit six no longer touches interrupt six.
      ext_int_six_out   <= alt_six_s;
      ext_int_seven_out <= seven_pin_s;
    end
  end

  // ---------------------------------------------------------------------
  // AXI4-Lite write channel.
  // ---------------------------------------------------------------------
  // Address and data are taken independently; ready drops while held so
  // a second write cannot overrun the first.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Ready flags: high while nothing is held, from a flop.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held &&
                           !(s_axi_awvalid_in && s_axi_awready_out);
      s_axi_wready_out  <= !w_held &&
                           !(s_axi_wvalid_in && s_axi_wready_out);
    end
  end

  // Write response, SLVERR for an unmapped address.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= KWM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= addr_ok(aw_addr) ? KWM_RESP_OKAY : KWM_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Address decode shared by both directions.
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    case (a[7:0])
      KWM_OFF_KEY_MASK_HIGH, KWM_OFF_KEY_MASK_LOW, KWM_OFF_WAKE_MASK_HIGH,
      KWM_OFF_WAKE_MASK_LOW, KWM_OFF_SYS_CTRL_THREE, KWM_OFF_EVENT_STATUS,
      KWM_OFF_EVENT_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // AXI4-Lite read channel.
  // ---------------------------------------------------------------------
  // Read data mux; upper bits read as zero.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_in[7:0])
      KWM_OFF_KEY_MASK_HIGH:  rd_word[7:0] = key_mask_high;
      KWM_OFF_KEY_MASK_LOW:   rd_word[7:0] = key_mask_low;
      KWM_OFF_WAKE_MASK_HIGH: rd_word[7:0] = wake_mask_high;
      KWM_OFF_WAKE_MASK_LOW:  rd_word[7:0] = wake_mask_low;
      KWM_OFF_SYS_CTRL_THREE: rd_word[KWM_BIT_MODE] = vector_mode_select;
      KWM_OFF_EVENT_STATUS:   rd_word[3:0] = event_status;
      KWM_OFF_EVENT_MASK:     rd_word[3:0] = event_mask;
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  // Address taken in a cycle with arready high; data the cycle after.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= KWM_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_word;
      s_axi_rresp_out   <= addr_ok(s_axi_araddr_in) ? KWM_RESP_OKAY
                                                    : KWM_RESP_SLVERR;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule // kwm_top

// [testbench/kwm_properties.sv]
// Port-level checker for the key and wake-up masking block.
`timescale 1ns/10ps
module kwm_checker
  import kwm_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [15:0] key_sense_in,
  input wire logic [15:0] wakeup_in,
  input wire logic        ext_int_six_pin_in,
  input wire logic        ext_int_seven_pin_in,
  input wire logic        alt_ext_int_six_pin_in,
  input wire logic        ext_int_six_out,
  input wire logic        ext_int_seven_out,
  input wire logic [3:0]  group_req_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // ---------------------------------------------------------------------
  // Sequences.
  // ---------------------------------------------------------------------
  // Every active-low pin released, so no source may be asserted.
  sequence pins_idle;
    &key_sense_in && &wakeup_in && ext_int_six_pin_in &&
      ext_int_seven_pin_in && alt_ext_int_six_pin_in;
  endsequence
  // No key or wake-up pin moved, so no falling edge can be seen.
  sequence pins_still;
    $stable(key_sense_in) && $stable(wakeup_in);
  endsequence
  // Address and data of a write taken together.
  sequence write_taken;
    s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out;
  endsequence

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  // Five cycles give margin over the three-edge pin path.
  AST_QUIET_SOURCES: assert property (pins_idle [*5] |->
    ext_int_six_out && ext_int_seven_out)
    else $error("Merged source low with all pins released");
  AST_NO_EDGE_NO_EVENT: assert property (pins_still [*5] |->
    group_req_out == 4'h0)
    else $error("Group request without a falling edge");
  AST_WRITE_ANSWER: assert property (write_taken |-> ##2
    s_axi_bvalid_out)
    else $error("Write answer not two cycles after taking");
  AST_WRITE_BLOCKED: assert property (write_taken |=>
    !s_axi_awready_out && !s_axi_wready_out)
    else $error("Second write accepted while one under way");
  AST_WRITE_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write answer dropped before taken");
  AST_RESP_CODE: assert property (s_axi_bvalid_out |->
    s_axi_bresp_out == KWM_RESP_OKAY || s_axi_bresp_out == KWM_RESP_SLVERR)
    else $error("Write answer code out of set");
  AST_READ_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("Read answer late or address still open");
  AST_READ_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) &&
      $stable(s_axi_rresp_out))
    else $error("Read answer changed before taken");
endmodule // kwm_checker

// [testbench/kwm_pin_model.sv]
// Model of the key matrix and wake-up pins on the far side.
`timescale 1ns/10ps
module kwm_pin_model (
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] key_press_in,
  input  wire logic [15:0] wake_press_in,
  input  wire logic [2:0]  line_press_in,
  output logic      [15:0] key_sense_out,
  output logic      [15:0] wake_out,
  output logic      [2:0]  line_out
);
  // Pins are pulled up, so a released pin reads high; a press pulls it
  // low one clock later, like a switch bouncing into a register.
  initial begin
    key_sense_out = 16'hFFFF;
    wake_out      = 16'hFFFF;
    line_out      = 3'h7;
  end
  always @(posedge ref_clk_in) begin
    key_sense_out <= ~key_press_in;
    wake_out      <= ~wake_press_in;
    line_out      <= ~line_press_in;
  end
endmodule // kwm_pin_model

// [testbench/tb.sv]
// Self-checking bench for the key and wake-up masking block.
`timescale 1ns/10ps
module tb;
  import kwm_pkg::*;
  logic        ref_clk_in = 0, resetn_in = 0;
  logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
  logic        s_axi_bready_in = 0, s_axi_arvalid_in = 0;
  logic        s_axi_rready_in = 0;
  logic [31:0] s_axi_wdata_in = 0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, irq_out;
  logic        ext_int_six_out, ext_int_seven_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [3:0]  group_req_out;
  logic [15:0] key_sense_in, wakeup_in;
  logic [2:0]  line;                      // Six, seven, alternate six.
  logic        ext_int_six_pin_in, ext_int_seven_pin_in;
  logic        alt_ext_int_six_pin_in;
  logic [15:0] key_press = 0, wake_press = 0;
  logic [2:0]  line_press = 0;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  int          pulses [4] = '{0, 0, 0, 0};  // Group pulses seen.
  logic [31:0] rst_val [5] = '{32'hFF, 32'hBF, 32'hFF, 32'hFF, 32'h0};
  assign {alt_ext_int_six_pin_in, ext_int_seven_pin_in} = line[2:1];
  assign ext_int_six_pin_in = line[0];

  kwm_top i_dut (.*);
  kwm_pin_model i_pins (.ref_clk_in, .key_press_in(key_press),
    .wake_press_in(wake_press), .line_press_in(line_press),
    .key_sense_out(key_sense_in), .wake_out(wakeup_in), .line_out(line));

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ---------------------------------------------------------------------
  // Pulse counting and hang guard.
  // ---------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    for (int i = 0; i < 4; i++) pulses[i] += int'(group_req_out[i] === 1);
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One AXI4-Lite write; each channel is released once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    while (!(aw && w)) begin
      @(posedge ref_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out === 1) begin
        aw = 1;
        s_axi_awvalid_in <= 0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out === 1) begin
        w = 1;
        s_axi_wvalid_in <= 0;
      end
    end
    do @(posedge ref_clk_in); while (s_axi_bvalid_out !== 1);
    // Ready comes only after the answer, so the slave must hold it.
    s_axi_bready_in <= 1;
    @(posedge ref_clk_in);
    chk("bresp", 32'(er), 32'(s_axi_bresp_out));
    s_axi_bready_in <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do @(posedge ref_clk_in); while (s_axi_arready_out !== 1);
    s_axi_arvalid_in <= 0;
    do @(posedge ref_clk_in); while (s_axi_rvalid_out !== 1);
    s_axi_rready_in <= 1;
    @(posedge ref_clk_in);
    chk("rdata", e, s_axi_rdata_out);
    chk("rresp", 32'(er), 32'(s_axi_rresp_out));
    s_axi_rready_in <= 0;
  endtask

  // Pin path is model flop plus three design edges.
  task automatic settle();
    repeat (6) @(posedge ref_clk_in);
  endtask

  // ---------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1;
    @(posedge ref_clk_in);
    chk("irq", 0, 32'(irq_out));
    for (int i = 0; i < 5; i++)
      rd(8'(4 * i), rst_val[i], 0);
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'h5A + i, 0);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h5A + i, 0);
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'hFF, 0);
    wr(8'h1C, 32'h1, KWM_RESP_SLVERR);
    rd(8'h1C, 32'h0, KWM_RESP_SLVERR);
    s_axi_wstrb_in <= 4'h0;
    wr(8'h00, 32'h00, 0);
    s_axi_wstrb_in <= 4'hF;
    rd(8'h00, 32'hFF, 0);
    // Compatible mode: pin six gated by key bit six.
    // Merged sources are judged as low levels, as sense is set.
    line_press <= 3'b001;
    settle();
    chk("six", 1, 32'(ext_int_six_out));
    wr(8'h04, 32'hBF, 0);
    settle();
    chk("six", 0, 32'(ext_int_six_out));
    line_press <= 3'b100;
    wr(8'h04, 32'hFE, 0);
    settle();
    chk("six", 1, 32'(ext_int_six_out));
    key_press <= 16'h0002;
    settle();
    chk("six", 1, 32'(ext_int_six_out));
    key_press <= 16'h0001;
    settle();
    chk("six", 0, 32'(ext_int_six_out));
    key_press <= 16'h8000;
    line_press <= 3'b010;
    wr(8'h00, 32'h7F, 0);
    settle();
    chk("seven", 0, 32'(ext_int_seven_out));
    key_press <= 0;
    settle();
    chk("seven", 1, 32'(ext_int_seven_out));
    wr(8'h00, 32'hFF, 0);
    settle();
    chk("seven", 0, 32'(ext_int_seven_out));
    line_press <= 0;
    wake_press <= 16'h8001;
    wr(8'h0C, 32'hFE, 0);
    wr(8'h08, 32'h00, 0);
    settle();
    chk("seven", 0, 32'(ext_int_seven_out));
    wake_press <= 16'h8000;
    settle();
    chk("seven", 1, 32'(ext_int_seven_out));
    wake_press <= 0;
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'hBF, 0);
    // Extended mode.
    wr(KWM_OFF_SYS_CTRL_THREE, 32'h1, 0);
    rd(8'h04, 32'hFF, 0);
    rd(KWM_OFF_SYS_CTRL_THREE, 32'h1, 0);
    wr(8'h04, 32'hBF, 0);
    line_press <= 3'b011;
    settle();
    chk("six", 1, 32'(ext_int_six_out));
    chk("seven", 0, 32'(ext_int_seven_out));
    line_press <= 3'b100;
    settle();
    chk("six", 0, 32'(ext_int_six_out));
    line_press <= 0;
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'hFF, 0);
    wr(KWM_OFF_EVENT_MASK, 32'hF, 0);
    for (int g = 0; g < 4; g++) begin
      wr(8'(4 * g), 32'hFE, 0);
      if (g < 2) key_press <= (g == 0) ? 16'h0100 : 16'h0001;
      else wake_press <= (g == 2) ? 16'h0100 : 16'h0001;
      settle();
      chk("pulses", 1, 32'(pulses[g]));
      rd(KWM_OFF_EVENT_STATUS, 32'h1 << g, 0);
      chk("irq", 1, 32'(irq_out));
      wr(KWM_OFF_EVENT_STATUS, 32'h1 << g, 0);
      chk("irq", 0, 32'(irq_out));
      wr(8'(4 * g), 32'hFF, 0);
      key_press <= 0;
      wake_press <= 0;
    end
    settle();
    key_press <= 16'hFFFF;
    wake_press <= 16'hFFFF;
    settle();
    rd(KWM_OFF_EVENT_STATUS, 32'h0, 0);
    key_press <= 0;
    wr(8'h04, 32'hFE, 0);
    wr(KWM_OFF_EVENT_MASK, 32'h0, 0);
    settle();
    key_press <= 16'h0001;
    settle();
    rd(KWM_OFF_EVENT_STATUS, 32'h2, 0);
    chk("irq", 0, 32'(irq_out));
    test_done();
  end
endmodule // tb

bind kwm_top kwm_checker i_chk (.*);
